// File: logic/watchdog_timeout_unit.sv
`timescale 1ns/1ps
// Overview of operation
// - 32-bit counter reloads and decrements while enabled
// - Zero count raises time-out; enable arms interrupt
// - First time-out reloads counter and keeps counting
// - Second zero with pending interrupt asserts reset
// - Clearing interrupt reloads counter and resumes
// - Reload write loads counter immediately
// - Reload write leaves pending interrupt set
// - Enabling interrupt preloads counter from reload
// - Interrupt enable starts counting, locks control
// - Guard write of any value but the unlock key locks reload, clear and control writes
// - Unlock key written to guard unlocks
// - Time-out drives NMI; reset alternative output
// - Zero reload value raises interrupt immediately
// - Clear write drops interrupt and reloads
// - Guard reads one locked, zero unlocked
// - Masked flag is raw AND enable
module watchdog_timeout_unit
  import watchdog_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic watchdog_gate_bit,
  input sw_write_type sw_write,
  output logic [31:0] timeout_reload_value,
  output logic [31:0] count_value,
  output logic reset_output_enable,
  output logic irq_enable,
  output logic raw_irq_flag,
  output logic masked_irq_flag,
  output logic [31:0] write_guard,
  output logic nmi_out,
  output logic sys_reset_out
);

  wd_state_type state_reg;
  wd_state_type state_next;
  logic gate_on;
  logic guard_open;
  logic ctrl_open;
  logic timeout;

  // Zero decode is shared by the time-out path and its checks
  function automatic logic at_zero(input logic [31:0] value);
    at_zero = (value == COUNT_ZERO);
  endfunction

  // The gate bit is driven from the clock controller, so it is resynchronised
  gate_sync u_gate_sync (
    .clock(clock),
    .rst_b(rst_b),
    .async_in(watchdog_gate_bit),
    .sync_out(gate_on)
  );

  always_comb
  begin
    state_next = state_reg;
    guard_open = gate_on && !state_reg.locked;
    // Control stays frozen once the interrupt is enabled; only reset reopens it
    ctrl_open = guard_open && !state_reg.irq_enable;
    timeout = gate_on && state_reg.irq_enable && at_zero(state_reg.count);
    if (gate_on && state_reg.irq_enable)
    begin
      if (timeout)
      begin
        // A zero reload keeps the counter at zero, so the flag rises at once
        state_next.raw_irq_flag = 1'b1;
        state_next.count = state_reg.timeout_reload_value;
        if (state_reg.raw_irq_flag && state_reg.reset_output_enable)
          state_next.sys_reset = 1'b1;
      end
      else
        state_next.count = state_reg.count - COUNT_STEP;
    end
    if (guard_open && sw_write.irq_clear_we)
    begin
      // A time-out in the same cycle wins over the clear
      state_next.raw_irq_flag = timeout;
      state_next.count = state_reg.timeout_reload_value;
    end
    if (guard_open && sw_write.reload_we)
    begin
      // Flag untouched here by design
      state_next.timeout_reload_value = sw_write.reload_data;
      state_next.count = sw_write.reload_data;
    end
    if (ctrl_open && sw_write.control_we)
    begin
      state_next.reset_output_enable = sw_write.reset_output_enable;
      state_next.irq_enable = sw_write.irq_enable;
      if (sw_write.irq_enable)
        state_next.count = sw_write.reload_we ? sw_write.reload_data
                                               : state_reg.timeout_reload_value;
    end
    if (gate_on && sw_write.guard_we)
      state_next.locked = (sw_write.guard_data != UNLOCK_KEY);
    state_next.nmi = state_next.raw_irq_flag && state_next.irq_enable;
    state_next.masked_irq_flag = state_next.raw_irq_flag && state_next.irq_enable;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      state_reg <= WD_STATE_RESET;
    else
      state_reg <= state_next;
  end

  assign timeout_reload_value = state_reg.timeout_reload_value;
  assign count_value = state_reg.count;
  assign reset_output_enable = state_reg.reset_output_enable;
  assign irq_enable = state_reg.irq_enable;
  assign raw_irq_flag = state_reg.raw_irq_flag;
  assign masked_irq_flag = state_reg.masked_irq_flag;
  assign write_guard = state_reg.locked ? GUARD_LOCKED_READ : GUARD_UNLOCKED_READ;
  assign nmi_out = state_reg.nmi;
  assign sys_reset_out = state_reg.sys_reset;

  sequence s_second_zero;
    gate_on && state_reg.irq_enable && state_reg.count == COUNT_ZERO
      && state_reg.raw_irq_flag && state_reg.reset_output_enable;
  endsequence

  sequence s_first_zero;
    gate_on && state_reg.irq_enable && state_reg.count == COUNT_ZERO
      && !(guard_open && (sw_write.reload_we || sw_write.irq_clear_we));
  endsequence

  a_count_decrement: assert property (@(posedge clock) disable iff (!rst_b)
    gate_on && state_reg.irq_enable && state_reg.count != COUNT_ZERO
      && !(guard_open && (sw_write.reload_we || sw_write.irq_clear_we))
    |=> state_reg.count == $past(state_reg.count) - COUNT_STEP)
    else $error("counter did not decrement by one");

  a_first_timeout: assert property (@(posedge clock) disable iff (!rst_b)
    s_first_zero |=> raw_irq_flag && nmi_out ##0 count_value == $past(timeout_reload_value))
    else $error("time-out did not raise flag and reload");

  a_second_reset: assert property (@(posedge clock) disable iff (!rst_b)
    s_second_zero |=> sys_reset_out)
    else $error("second time-out did not assert reset");

  a_reset_gated: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(sys_reset_out) |-> $past(reset_output_enable) && $past(raw_irq_flag))
    else $error("reset rose without enable and pending flag");

  a_reload_write: assert property (@(posedge clock) disable iff (!rst_b)
    guard_open && sw_write.reload_we |=> count_value == $past(sw_write.reload_data))
    else $error("reload write did not load counter");

  a_reload_keeps: assert property (@(posedge clock) disable iff (!rst_b)
    raw_irq_flag && !(guard_open && sw_write.irq_clear_we) |=> raw_irq_flag)
    else $error("flag dropped without a clear write");

  a_clear_reload: assert property (@(posedge clock) disable iff (!rst_b)
    guard_open && sw_write.irq_clear_we && !sw_write.reload_we && !timeout
    |=> !raw_irq_flag && count_value == $past(timeout_reload_value))
    else $error("clear did not drop flag and reload");

  a_ctrl_frozen: assert property (@(posedge clock) disable iff (!rst_b)
    irq_enable |=> irq_enable && $stable(reset_output_enable))
    else $error("control changed after enable");

  a_guard_lock: assert property (@(posedge clock) disable iff (!rst_b)
    gate_on && sw_write.guard_we && sw_write.guard_data != UNLOCK_KEY
    |=> write_guard == GUARD_LOCKED_READ ##1 1'b1)
    else $error("guard write did not lock");

  a_guard_unlock: assert property (@(posedge clock) disable iff (!rst_b)
    gate_on && sw_write.guard_we && sw_write.guard_data == UNLOCK_KEY
    |=> write_guard == GUARD_UNLOCKED_READ)
    else $error("unlock key did not unlock");

  a_masked_and: assert property (@(posedge clock) disable iff (!rst_b)
    masked_irq_flag == (raw_irq_flag && irq_enable))
    else $error("masked flag is not raw AND enable");

  sequence s_reloaded_run;
    s_first_zero ##1 (gate_on && state_reg.irq_enable && !at_zero(state_reg.count)
      && !(guard_open && (sw_write.reload_we || sw_write.irq_clear_we)));
  endsequence

  a_reload_continue: assert property (@(posedge clock) disable iff (!rst_b)
    s_reloaded_run |=> count_value == $past(count_value) - COUNT_STEP)
    else $error("counter did not resume after reload");

  a_clear_resume: assert property (@(posedge clock) disable iff (!rst_b)
    guard_open && sw_write.irq_clear_we && raw_irq_flag && !timeout
    |=> !raw_irq_flag && $stable(sys_reset_out))
    else $error("clear before second zero did not resume");

  a_enable_preload: assert property (@(posedge clock) disable iff (!rst_b)
    ctrl_open && sw_write.control_we && sw_write.irq_enable && !sw_write.reload_we
    |=> irq_enable && count_value == $past(timeout_reload_value))
    else $error("enable did not preload the counter");

  a_nmi_level: assert property (@(posedge clock) disable iff (!rst_b)
    nmi_out == (raw_irq_flag && irq_enable))
    else $error("nmi does not follow the pending flag");

  // Zero reload keeps the counter parked, so every enabled cycle is a time-out
  a_zero_reload: assert property (@(posedge clock) disable iff (!rst_b)
    gate_on && state_reg.irq_enable && at_zero(state_reg.count)
      && at_zero(state_reg.timeout_reload_value) && !(guard_open && sw_write.reload_we)
    |=> raw_irq_flag && at_zero(count_value))
    else $error("zero reload did not raise the flag");

  a_locked_read: assert property (@(posedge clock) disable iff (!rst_b)
    write_guard == GUARD_LOCKED_READ && sw_write.reload_we
    |=> $stable(timeout_reload_value))
    else $error("reload taken while guard reads locked");

  a_gate_hold: assert property (@(posedge clock) disable iff (!rst_b)
    !gate_on |=> $stable(count_value) && $stable(raw_irq_flag) && $stable(irq_enable))
    else $error("state moved while the clock gate was off");

  a_reset_sticky: assert property (@(posedge clock) disable iff (!rst_b)
    sys_reset_out |=> sys_reset_out)
    else $error("system reset output dropped");

endmodule

// File: logic/watchdog_pkg.sv
package watchdog_pkg;

  localparam int unsigned COUNT_WIDTH = 32;
  localparam logic [31:0] RELOAD_RESET_VALUE = 32'hFFFFFFFF;
  localparam logic [31:0] COUNT_RESET_VALUE = 32'hFFFFFFFF;
  localparam logic [31:0] UNLOCK_KEY = 32'h1ACCE551;
  localparam logic [31:0] COUNT_ZERO = 32'h00000000;
  localparam logic [31:0] COUNT_STEP = 32'h00000001;
  localparam logic [31:0] GUARD_LOCKED_READ = 32'h00000001;
  localparam logic [31:0] GUARD_UNLOCKED_READ = 32'h00000000;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  // Software write strobes with their data, one-cycle pulses from the processor side
  typedef struct packed {
    logic reload_we;
    logic [31:0] reload_data;
    logic control_we;
    logic reset_output_enable;
    logic irq_enable;
    logic irq_clear_we;
    logic guard_we;
    logic [31:0] guard_data;
  } sw_write_type;

  typedef struct packed {
    logic [31:0] timeout_reload_value;
    logic [31:0] count;
    logic reset_output_enable;
    logic irq_enable;
    logic raw_irq_flag;
    logic locked;
    logic sys_reset;
    logic nmi;
    logic masked_irq_flag;
  } wd_state_type;

  localparam wd_state_type WD_STATE_RESET = '{
    timeout_reload_value: RELOAD_RESET_VALUE,
    count: COUNT_RESET_VALUE,
    reset_output_enable: 1'b0,
    irq_enable: 1'b0,
    raw_irq_flag: 1'b0,
    locked: 1'b0,
    sys_reset: 1'b0,
    nmi: 1'b0,
    masked_irq_flag: 1'b0
  };

endpackage

// File: logic/gate_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for the clock gating bit, which comes from another block's domain
module gate_sync
  import watchdog_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic async_in,
  output logic sync_out
);

  logic [1:0] stage_reg;
  logic [1:0] stage_next;

  always_comb
  begin
    stage_next = {stage_reg[0], async_in};
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      stage_reg <= SYNC_RESET;
    else
      stage_reg <= stage_next;
  end

  assign sync_out = stage_reg[1];

endmodule

// File: sim/wd_nmi_host.sv
`timescale 1ns/1ps
// Processor stand-in: its handler clears an NMI a set number of cycles after it rises
module wd_nmi_host (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic nmi,
  input wire logic handler_on,
  input wire logic [3:0] delay,
  output logic ack
);
  logic [3:0] age_reg;
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      age_reg <= 4'h0;
      ack <= 1'b0;
    end
    else
    begin
      age_reg <= nmi ? age_reg + 4'h1 : 4'h0;
      ack <= handler_on && nmi && age_reg == delay;
    end
  end
endmodule

// File: sim/watchdog_timeout_unit_tb_top.sv
`timescale 1ns/1ps
module watchdog_timeout_unit_tb_top;
  import watchdog_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic gate = 1'b1;
  logic host_on = 1'b0;
  logic ack;
  sw_write_type sw = '0;
  sw_write_type sw_all;
  logic [31:0] rv, cv, wg;
  logic ren, ien, raw, mis, nmi, srst;
  int unsigned m_rl, m_cn;
  bit m_re, m_ie, m_raw, m_lk, m_rst, tmo;
  bit [1:0] m_g;
  int n_fail = 0;
  int total_checks = 0;
  int i;
  always #2.5 clock = ~clock;
  always_comb
  begin
    sw_all = sw;
    sw_all.irq_clear_we = sw.irq_clear_we | ack;
  end
  watchdog_timeout_unit u_watchdog_timeout_unit (.clock(clock), .rst_b(rst_b),
    .watchdog_gate_bit(gate), .sw_write(sw_all), .timeout_reload_value(rv),
    .count_value(cv), .reset_output_enable(ren), .irq_enable(ien), .raw_irq_flag(raw),
    .masked_irq_flag(mis), .write_guard(wg), .nmi_out(nmi), .sys_reset_out(srst));
  wd_nmi_host u_wd_nmi_host (.clock(clock), .rst_b(rst_b), .nmi(nmi),
    .handler_on(host_on), .delay(4'h2), .ack(ack));
  // Reference model; the gate passes two flops, so writes are judged on the delayed copy
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      {m_rl, m_cn} = {32'hFFFFFFFF, 32'hFFFFFFFF};
      {m_re, m_ie, m_raw, m_lk, m_rst, m_g} = '0;
    end
    else
    begin
      if (m_g[1])
      begin
        // Later steps override earlier ones: count, clear, reload, control
        tmo = m_ie && m_cn == 0;
        if (tmo)
        begin
          m_rst = m_rst | (m_raw & m_re);
          {m_raw, m_cn} = {1'b1, m_rl};
        end
        else if (m_ie)
          m_cn--;
        if (sw_all.irq_clear_we && !m_lk)
          {m_raw, m_cn} = {tmo, m_rl};
        if (sw_all.reload_we && !m_lk)
          {m_rl, m_cn} = {sw_all.reload_data, sw_all.reload_data};
        if (sw_all.control_we && !m_lk && !m_ie)
        begin
          {m_re, m_ie} = {sw_all.reset_output_enable, sw_all.irq_enable};
          if (m_ie)
            m_cn = m_rl;
        end
        if (sw_all.guard_we)
          m_lk = sw_all.guard_data != UNLOCK_KEY;
      end
      m_g = {m_g[0], gate};
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  always @(negedge clock)
    if (rst_b)
    begin
      chk(cv, m_cn);
      chk(rv, m_rl);
      chk(wg, {31'h0, m_lk});
      chk({26'h0, ren, ien, raw, mis, nmi, srst},
        {26'h0, m_re, m_ie, m_raw, m_raw & m_ie, m_raw & m_ie, m_rst});
    end
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic step(input int n);
    sw = '0;
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Kinds: 0 reload, 1 clear, 2 guard, 3 control, others idle
  task automatic wr(input int k, input logic [31:0] d);
    sw_write_type w;
    w = '0;
    case (k)
      0: {w.reload_we, w.reload_data} = {1'b1, d};
      1: w.irq_clear_we = 1'b1;
      2: {w.guard_we, w.guard_data} = {1'b1, d};
      3: {w.control_we, w.reset_output_enable, w.irq_enable} = {1'b1, d[1:0]};
      default: ;
    endcase
    sw = w;
    @(posedge clock);
    #1;
  endtask
  task automatic wait_hi(input bit on_rst);
    for (i = 0; i < 200 && (on_rst ? srst : nmi) !== 1'b1; i++)
      step(1);
    if ((on_rst ? srst : nmi) !== 1'b1)
    begin
      n_fail++;
      conclude();
    end
  endtask
  task automatic do_reset();
    rst_b = 1'b0;
    repeat (20) @(posedge clock);
    #1;
    rst_b = 1'b1;
    step(4);
  endtask
  initial
  begin
    void'($urandom(32'hA4AAE78D));
    do_reset();
    wr(0, 32'h6);
    wr(3, 32'h2);
    wr(3, 32'h3);
    wr(3, 32'h0);
    wait_hi(1'b0);
    step(2);
    wr(0, 32'h4);
    wr(1, 32'h0);
    wait_hi(1'b1);
    wr(2, $urandom & 32'h0FFFFFFF);
    wr(0, 32'h9);
    wr(1, 32'h0);
    wr(2, UNLOCK_KEY);
    do_reset();
    wr(0, 32'h0);
    wr(3, 32'h1);
    wait_hi(1'b0);
    wr(1, 32'h0);
    wr(0, 32'h8);
    host_on = 1'b1;
    step(40);
    host_on = 1'b0;
    gate = 1'b0;
    step(4);
    wr(0, 32'h3);
    step(3);
    gate = 1'b1;
    do_reset();
    for (int j = 0; j < 400; j++)
      if (m_cn > 1 || !m_ie)
        wr($urandom % 6, ($urandom % 3 == 0) ? UNLOCK_KEY : $urandom % 12);
      else
        step(1);
    step(5);
    conclude();
  end
endmodule
